/* hdl/tdm_pkg.sv */
package tdm_pkg;
    localparam int CLK_KHZ = 100000;
    localparam int CLK_PS = 10000;
    localparam int BIT_KHZ = 8192;
    localparam int CH_DEF = 32;
    // Register byte offsets and regions
    localparam logic [15:0] OFS_OTC = 16'h0000;
    localparam logic [15:0] OFS_GCW = 16'h0004;
    localparam logic [15:0] OFS_INIT_VAL = 16'h0008;
    localparam logic [15:0] OFS_INIT_EN = 16'h000c;
    localparam logic [15:0] OFS_REF_RATE = 16'h0010;
    localparam logic [15:0] OFS_STATUS = 16'h0014;
    localparam logic [3:0] RGN_REG = 4'h0;
    localparam logic [3:0] RGN_CM = 4'h1;
    localparam logic [3:0] RGN_CM_LSB = 4'h2;
    localparam logic [3:0] RGN_DM = 4'h3;
    // Reset values
    localparam logic [31:0] RST_OTC = 32'h0004080c;
    localparam logic [31:0] RST_GCW = 32'h00000000;
    localparam logic [31:0] RST_INIT_VAL = 32'h00000000;
    localparam logic [7:0] RST_REF_RATE = 8'h00;
    localparam logic [31:0] GCW_MASK = 32'h003301f3;
    // Group word fields
    localparam int GC_ISRC = 0;
    localparam int GC_DLY = 4;
    localparam int GC_OSRC = 16;
    localparam int GC_ADV = 20;
    // Output timing byte fields
    localparam int OT_SRC = 0;
    localparam int OT_RATE = 2;
    localparam int OT_CKPOL = 4;
    localparam int OT_FPPOL = 5;
    localparam int OT_FMT = 6;
    localparam int RR_STREAM = 6;
    // Per-channel function codes
    localparam logic [2:0] FN_HIZ = 3'h0;
    localparam logic [2:0] FN_HIGH = 3'h1;
    localparam logic [2:0] FN_MESSAGE = 3'h2;
    localparam logic [2:0] FN_VAR = 3'h3;
    localparam logic [2:0] FN_CONST = 3'h4;
    localparam logic [2:0] FN_SPARE = 3'h5;
    // Sampling points in quarter bits
    localparam logic [2:0] BASE_Q_NOM = 3'h3;
    localparam logic [2:0] BASE_Q_MID = 3'h2;
    localparam int VAR_MIN_CH = 3;
    // Output advance steps
    localparam int ADV_STEP_PS = 7600;
    localparam int ADV_FAST_PS = 3800;
    localparam int EXT65_KHZ = 65536;
    localparam int EXT32_KHZ = 32768;
    function automatic int ps2cyc(input int ps);
        return (ps / CLK_PS < 1) ? 1 : ps / CLK_PS;
    endfunction
    localparam int ADV_CYC = ps2cyc(ADV_STEP_PS);
    localparam int ADV_CYC_FAST = ps2cyc(ADV_FAST_PS);
    localparam int ADV_CYC_E65 = ps2cyc(500000000 / EXT65_KHZ);
    localparam int ADV_CYC_E32 = ps2cyc(500000000 / EXT32_KHZ);
    localparam int ADV_MAX = 3 * ADV_CYC_E32;
    // Phase increments for 16-bit accumulators
    localparam logic [15:0] QINC =
        16'((64'd4 * BIT_KHZ * 64'd65536) / CLK_KHZ);
    localparam logic [15:0] OINC8 =
        16'((64'd8192 * 64'd65536) / CLK_KHZ);
endpackage

/* hdl/tdm_switch_timing.sv */
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module tdm_switch_timing
    import tdm_pkg::*;
#(
    parameter int CH = CH_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Timing pins
    input wire logic master_frame_marker_n,
    input wire logic [2:0] input_reference_clock,
    // Streams
    input wire logic stream_in,
    output logic stream_out,
    output logic stream_out_oe,
    // Output timing pairs
    output logic [3:0] out_timing_clock,
    output logic [3:0] out_frame_marker
);

localparam int CW = $clog2(CH);
localparam int QW = CW + 5;
localparam int INIT_BOUND = CH + 1;

generate
    if (CH < 8 || CH > 512 || (1 << CW) != CH) begin : g_chk
        $error("CH must be a power of two from 8 to 512");
    end
endgenerate

function automatic logic [1:0] inc3(input logic [1:0] b);
    return (b == 2'd2) ? 2'd0 : b + 2'd1;
endfunction

function automatic logic [1:0] dec3(input logic [1:0] b);
    return (b == 2'd0) ? 2'd2 : b - 2'd1;
endfunction

function automatic logic [1:0] rate_of(input logic [1:0] src,
                                       input logic [7:0] rr);
    return (src == 2'd0) ? rr[RR_STREAM +: 2]
                         : rr[{src - 2'd1, 1'b0} +: 2];
endfunction

////////////////////////////////////////////////////////////////////////
// Pin synchronisers

logic [4:0] s1_q, s2_q, s3_q;
logic fm_fall, din;
logic [2:0] ref_rise;

always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        s1_q <= 5'h08;
        s2_q <= 5'h08;
        s3_q <= 5'h08;
    end else begin
        s1_q <= {stream_in, master_frame_marker_n, input_reference_clock};
        s2_q <= s1_q;
        s3_q <= s2_q;
    end
end

assign fm_fall = s3_q[3] & ~s2_q[3];
assign ref_rise = s2_q[2:0] & ~s3_q[2:0];
assign din = s2_q[4];

////////////////////////////////////////////////////////////////////////
// Quarter-bit timebase and frame counter

logic [15:0] acc_q, acc_d;
logic [QW-1:0] qcnt_q, qcnt_d;
logic qtick, qtick_q, restart;

always_comb begin
    {qtick, acc_d} = {1'b0, acc_q} + {1'b0, QINC};
    qcnt_d = qtick ? qcnt_q + QW'(1) : qcnt_q;
    // A marker in the first bit finds the wrap already done
    restart = fm_fall && (qcnt_q[QW-1:2] != '0);
    if (restart) begin
        acc_d = 16'h0000;
        qcnt_d = '0;
    end
end

always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        acc_q <= 16'h0000;
        qcnt_q <= '0;
        qtick_q <= 1'b0;
    end else begin
        acc_q <= acc_d;
        qcnt_q <= qcnt_d;
        // Restart is the tick into quarter 0, so channel 0 still loads
        qtick_q <= qtick | restart;
    end
end

////////////////////////////////////////////////////////////////////////
// Registers and memories

logic [31:0] output_timing_config_q, otc_d;
logic [31:0] group_config_word_q, gcw_d;
logic [31:0] init_val_q, init_val_d;
logic init_en_q, init_en_d;
logic [CW-1:0] init_idx_q, init_idx_d;
logic [7:0] ref_rate_q, ref_rate_d;
logic [1:0] ib_q, ib_d, ob_q, ob_d;
logic [31:0] cmem [CH];
logic [7:0] dmem [3][CH];

logic [1:0] in_stream_clk_select, out_stream_clk_select;
logic [4:0] input_sample_delay_field;
logic [1:0] output_advance_field;

assign in_stream_clk_select = group_config_word_q[GC_ISRC +: 2];
assign out_stream_clk_select = group_config_word_q[GC_OSRC +: 2];
assign input_sample_delay_field = group_config_word_q[GC_DLY +: 5];
assign output_advance_field = group_config_word_q[GC_ADV +: 2];

////////////////////////////////////////////////////////////////////////
// Input sampling

logic half, sample, dm_we;
logic [4:0] qd;
logic [2:0] base;
logic [QW-1:0] sc;
logic [7:0] ish_q, ish_d;

always_comb begin
    half = (in_stream_clk_select != 2'd0) &&
           (rate_of(in_stream_clk_select, ref_rate_q) ==
            ref_rate_q[RR_STREAM +: 2]);
    qd = half ? {input_sample_delay_field[4:1], 1'b0}
              : input_sample_delay_field;
    base = half ? BASE_Q_MID : BASE_Q_NOM;
    sc = qcnt_q - QW'(base) - QW'(qd);
    sample = qtick_q && (sc[1:0] == 2'd0);
    ish_d = sample ? {ish_q[6:0], din} : ish_q;
    dm_we = sample && (sc[4:2] == 3'd7);
    ib_d = (dm_we && sc[QW-1:5] == '1) ? inc3(ib_q) : ib_q;
end

always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        ish_q <= 8'h00;
        ib_q <= 2'd0;
    end else begin
        ish_q <= ish_d;
        ib_q <= ib_d;
    end
end

////////////////////////////////////////////////////////////////////////
// Output channel path

logic load;
logic [CW-1:0] och, src_ch;
logic [31:0] cw;
logic [2:0] fn;
logic [1:0] obn, vb, cb, orate;
logic [7:0] obyte, osh_q, osh_d;
logic oen, ooe_q, ooe_d;
logic [2:0] step;
logic [3:0] adv;
logic [ADV_MAX:0] dl_q, dl_d, ol_q, ol_d;
logic so_d, soe_d;

always_comb begin
    och = qcnt_q[QW-1:5];
    load = qtick_q && (qcnt_q[4:0] == 5'd0);
    cw = cmem[och];
    fn = cw[31:29];
    src_ch = cw[CW+7:8];
    obn = (och == '0) ? inc3(ob_q) : ob_q;
    vb = ({1'b0, src_ch} + (CW+1)'(VAR_MIN_CH) <= {1'b0, och}) ? obn
                                                   : dec3(obn);
    cb = dec3(dec3(obn));
    unique case (fn)
        FN_HIGH: obyte = 8'hff;
        FN_MESSAGE: obyte = cw[7:0];
        FN_VAR, FN_SPARE: obyte = dmem[vb][src_ch];
        FN_CONST: obyte = dmem[cb][src_ch];
        default: obyte = 8'h00;
    endcase
    oen = (fn inside {FN_HIGH, FN_MESSAGE, FN_VAR, FN_CONST,
                      FN_SPARE});
    osh_d = load ? obyte : (qtick_q && qcnt_q[1:0] == 2'd0)
                           ? {osh_q[6:0], 1'b0} : osh_q;
    ooe_d = load ? oen : ooe_q;
    ob_d = load ? obn : ob_q;
    orate = rate_of(out_stream_clk_select, ref_rate_q);
    if (out_stream_clk_select != 2'd0) begin
        step = (orate == 2'd3) ? 3'(ADV_CYC_E65) :
               (orate == 2'd2) ? 3'(ADV_CYC_E32) : 3'd0;
    end else begin
        step = (ref_rate_q[RR_STREAM +: 2] == 2'd3) ? 3'(ADV_CYC_FAST)
                                                  : 3'(ADV_CYC);
    end
    adv = 4'(output_advance_field * step);
    dl_d = {dl_q[ADV_MAX-1:0], osh_q[7]};
    ol_d = {ol_q[ADV_MAX-1:0], ooe_q & ~init_en_q};
    so_d = dl_q[ADV_MAX - int'(adv)];
    soe_d = ol_q[ADV_MAX - int'(adv)] & ~init_en_q;
end

always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        osh_q <= 8'h00;
        ooe_q <= 1'b0;
        ob_q <= 2'd2;
        dl_q <= '0;
        ol_q <= '0;
        stream_out <= 1'b0;
        stream_out_oe <= 1'b0;
    end else begin
        osh_q <= osh_d;
        ooe_q <= ooe_d;
        ob_q <= ob_d;
        dl_q <= dl_d;
        ol_q <= ol_d;
        stream_out <= so_d;
        stream_out_oe <= soe_d;
    end
end

////////////////////////////////////////////////////////////////////////
// Output clock and frame-marker pairs

logic [3:0][15:0] pacc_q, pacc_d;
logic [3:0][2:0] pcnt_q, pcnt_d;
logic [3:0] ck_d, fm_d;

always_comb begin
    logic [7:0] cfg;
    logic [1:0] rs, rr, k;
    logic ck, fa;
    cfg = 8'h00;
    rs = 2'd0;
    rr = 2'd0;
    k = 2'd0;
    ck = 1'b0;
    fa = 1'b0;
    for (int i = 0; i < 4; i++) begin
        cfg = output_timing_config_q[8*i +: 8];
        pacc_d[i] = pacc_q[i] + (OINC8 << cfg[OT_RATE +: 2]);
        pcnt_d[i] = pcnt_q[i];
        if (cfg[OT_SRC +: 2] != 2'd0) begin
            rs = cfg[OT_SRC +: 2] - 2'd1;
            rr = ref_rate_q[{rs, 1'b0} +: 2];
            k = (rr > cfg[OT_RATE +: 2]) ? rr - cfg[OT_RATE +: 2] : 2'd0;
            pcnt_d[i] = pcnt_q[i] + 3'(ref_rise[rs]);
            ck = (k == 2'd0) ? s2_q[rs] : pcnt_q[i][k - 2'd1];
        end else begin
            ck = pacc_q[i][15];
        end
        fa = cfg[OT_FMT] ? (qcnt_q[QW-1:2] == '0)
                         : (qcnt_q[QW-1:1] == '1 ||
                            qcnt_q[QW-1:1] == '0);
        ck_d[i] = ck ^ cfg[OT_CKPOL];
        fm_d[i] = cfg[OT_FPPOL] ? fa : ~fa;
    end
end

always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        pacc_q <= '0;
        pcnt_q <= '0;
        out_timing_clock <= 4'h0;
        out_frame_marker <= 4'hf;
    end else begin
        pacc_q <= pacc_d;
        pcnt_q <= pcnt_d;
        out_timing_clock <= ck_d;
        out_frame_marker <= fm_d;
    end
end

////////////////////////////////////////////////////////////////////////
// Wishbone slave

logic req, wr, cm_hit, lsb_hit, dm_hit;
logic [3:0] rgn;
logic [CW-1:0] wi;
logic [CW-3:0] qi;
logic [31:0] rd, rdat_q, rdat_d, wmask;
logic ack_q, ack_d, err_q, err_d;

function automatic logic [31:0] bytes_of(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
endfunction

always_comb begin
    logic [CW-1:0] ch;
    ch = '0;
    rgn = wb_adr_i[15:12];
    wi = wb_adr_i[CW+1:2];
    qi = wb_adr_i[CW-1:2];
    cm_hit = (rgn == RGN_CM) && (wb_adr_i[11:CW+2] == '0);
    lsb_hit = (rgn == RGN_CM_LSB) && (wb_adr_i[11:CW] == '0);
    dm_hit = (rgn == RGN_DM) && (wb_adr_i[11:CW] == '0);
    req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
    wmask = bytes_of(wb_sel_i);
    rd = 32'h0;
    if (rgn == RGN_REG) begin
        unique case (wb_adr_i)
            OFS_OTC: rd = output_timing_config_q;
            OFS_GCW: rd = group_config_word_q;
            OFS_INIT_VAL: rd = init_val_q;
            OFS_INIT_EN: rd = {31'h0, init_en_q};
            OFS_REF_RATE: rd = {24'h0, ref_rate_q};
            OFS_STATUS: rd = {28'h0, ib_q, ob_q};
            default: rd = 32'h0;
        endcase
    end else if (cm_hit) begin
        rd = cmem[wi];
    end else if (lsb_hit || dm_hit) begin
        for (int l = 0; l < 4; l++) begin
            ch = {qi, 2'(3 - l)};
            rd[8*l +: 8] = lsb_hit ? cmem[ch][7:0]
                                   : dmem[dec3(ib_q)][ch];
        end
    end
    ack_d = req && !(dm_hit && wb_we_i);
    err_d = req && dm_hit && wb_we_i;
    rdat_d = req ? rd : rdat_q;
    otc_d = output_timing_config_q;
    gcw_d = group_config_word_q;
    init_val_d = init_val_q;
    ref_rate_d = ref_rate_q;
    init_en_d = init_en_q;
    init_idx_d = init_en_q ? init_idx_q + CW'(1) : '0;
    if (init_en_q && init_idx_q == '1) begin
        init_en_d = 1'b0;
    end
    if (wr && rgn == RGN_REG) begin
        unique case (wb_adr_i)
            OFS_OTC: otc_d = (otc_d & ~wmask) | (wb_dat_i & wmask);
            OFS_GCW: gcw_d = ((gcw_d & ~wmask) | (wb_dat_i & wmask))
                             & GCW_MASK;
            OFS_INIT_VAL:
                init_val_d = (init_val_d & ~wmask) | (wb_dat_i & wmask);
            OFS_INIT_EN: begin
                if (wb_sel_i[0]) begin
                    init_en_d = wb_dat_i[0];
                end
            end
            OFS_REF_RATE: begin
                if (wb_sel_i[0]) begin
                    ref_rate_d = wb_dat_i[7:0];
                end
            end
            default: ;
        endcase
    end
end

always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        output_timing_config_q <= RST_OTC;
        group_config_word_q <= RST_GCW;
        init_val_q <= RST_INIT_VAL;
        init_en_q <= 1'b0;
        init_idx_q <= '0;
        ref_rate_q <= RST_REF_RATE;
        ack_q <= 1'b0;
        err_q <= 1'b0;
        rdat_q <= 32'h0;
    end else begin
        output_timing_config_q <= otc_d;
        group_config_word_q <= gcw_d;
        init_val_q <= init_val_d;
        init_en_q <= init_en_d;
        init_idx_q <= init_idx_d;
        ref_rate_q <= ref_rate_d;
        ack_q <= ack_d;
        err_q <= err_d;
        rdat_q <= rdat_d;
    end
end

assign wb_ack_o = ack_q;
assign wb_err_o = err_q;
assign wb_dat_o = rdat_q;

always_ff @(posedge clk) begin
    if (init_en_q) begin
        cmem[init_idx_q] <= init_val_q;
    end else if (wr && cm_hit) begin
        cmem[wi] <= (cmem[wi] & ~wmask) | (wb_dat_i & wmask);
    end else if (wr && lsb_hit) begin
        for (int l = 0; l < 4; l++) begin
            if (wb_sel_i[l]) begin
                cmem[{qi, 2'(3 - l)}][7:0] <= wb_dat_i[8*l +: 8];
            end
        end
    end
    if (dm_we) begin
        dmem[ib_q][sc[QW-1:5]] <= ish_d;
    end
end

////////////////////////////////////////////////////////////////////////
// Assertions

property p_rst_cfg;
    @(posedge clk) $rose(reset_n) |->
        output_timing_config_q == 32'h0004080c;
endproperty
a_rst_cfg: assert property (p_rst_cfg)
    else $error("output timing reset value wrong");

property p_hiz;
    @(posedge clk) disable iff (!reset_n)
    load && fn inside {3'h0, 3'h6, 3'h7} |=> !ooe_q;
endproperty
a_hiz: assert property (p_hiz)
    else $error("tri-state channel enabled");

property p_high;
    @(posedge clk) disable iff (!reset_n)
    load && fn == 3'h1 |=> osh_q == 8'hff && ooe_q;
endproperty
a_high: assert property (p_high)
    else $error("forced high channel wrong");

property p_msg;
    @(posedge clk) disable iff (!reset_n)
    load && fn == 3'h2 |=> osh_q == $past(cw[7:0]) && ooe_q;
endproperty
a_msg: assert property (p_msg)
    else $error("message byte not loaded");

property p_init_done;
    @(posedge clk) disable iff (!reset_n)
    $rose(init_en_q) |-> ##[1:INIT_BOUND] !init_en_q;
endproperty
a_init_done: assert property (p_init_done)
    else $error("block init did not finish");

property p_init_hiz;
    @(posedge clk) disable iff (!reset_n)
    init_en_q [*2] |-> !stream_out_oe;
endproperty
a_init_hiz: assert property (p_init_hiz)
    else $error("stream driven during block init");

property p_dm_err;
    @(posedge clk) disable iff (!reset_n)
    req && dm_hit && wb_we_i |=> wb_err_o && !wb_ack_o;
endproperty
a_dm_err: assert property (p_dm_err)
    else $error("input data write not refused");

property p_sample_nom;
    @(posedge clk) disable iff (!reset_n)
    qtick_q && !half && input_sample_delay_field == 5'd0 &&
    qcnt_q[1:0] == 2'd3 |-> sample;
endproperty
a_sample_nom: assert property (p_sample_nom)
    else $error("zero delay not at three quarters");

property p_sample_mid;
    @(posedge clk) disable iff (!reset_n)
    qtick_q && half && input_sample_delay_field[4:1] == 4'd0 &&
    qcnt_q[1:0] == 2'd2 |-> sample;
endproperty
a_sample_mid: assert property (p_sample_mid)
    else $error("equal rate source not mid-bit");

property p_no_adv;
    @(posedge clk) disable iff (!reset_n)
    out_stream_clk_select != 2'd0 && orate < 2'd2 |-> adv == 4'd0;
endproperty
a_no_adv: assert property (p_no_adv)
    else $error("advance applied with slow source");

endmodule

/* testbench/tdm_far_end.sv */
`timescale 1ns/1ps
// Far-side serial device: master frame marker, input stream, 8 MHz reference clock 0
module tdm_far_end #(
    parameter int CH = 8
) (
    // Timing pins
    output logic master_frame_marker_n,
    output logic [2:0] input_reference_clock,
    // Stream
    output logic stream_in
);
    localparam realtime BIT_NS = 122.0703125;
    initial begin
        input_reference_clock = 3'h0;
        forever begin
            #62.5 input_reference_clock[0] = ~input_reference_clock[0];
        end
    end
    // Channel k carries byte 8'h10 + k, bit 7 first after the marker
    initial begin
        master_frame_marker_n = 1'b1;
        stream_in = 1'b1;
        #1000;
        forever begin
            for (int k = 0; k < CH; k++) begin
                for (int b = 7; b >= 0; b--) begin
                    master_frame_marker_n = !(k == 0 && b == 7);
                    stream_in = 1'(8'(8'h10 + k) >> b);
                    #(BIT_NS);
                end
            end
        end
    end
endmodule

/* testbench/tdm_switch_timing_and_channel_control_test.sv */
`timescale 1ns/1ps
module tdm_switch_timing_and_channel_control_test;
    import tdm_pkg::*;
    localparam int CH = 8;
    logic clk = 0;
    logic reset_n = 0;
    logic cyc = 0, stb = 0, we = 0;
    logic [15:0] adr = 16'h0000;
    logic [31:0] dat = 32'h00000000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_o;
    logic ack, err, fm_n, s_in, s_out, s_oe;
    logic [2:0] ref_ck;
    logic [3:0] ck_o, fm_o;
    int n_errors = 0;
    int tests_run = 0;
    logic [31:0] q;
    logic e;
    int hi, lo, z, fl;
    int ne[4];

    always #5 clk = ~clk;

    tdm_switch_timing #(.CH(CH)) u_dut (
        .clk(clk), .reset_n(reset_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .wb_err_o(err),
        .master_frame_marker_n(fm_n), .input_reference_clock(ref_ck),
        .stream_in(s_in), .stream_out(s_out), .stream_out_oe(s_oe),
        .out_timing_clock(ck_o), .out_frame_marker(fm_o)
    );

    tdm_far_end #(.CH(CH)) u_far (
        .master_frame_marker_n(fm_n),
        .input_reference_clock(ref_ck),
        .stream_in(s_in)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic end_of_test();
        if (n_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Classic single cycle; request held until ack or err is sampled
    task automatic bus(input int w, input logic [15:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= 1'(w);
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 100);
        if (n >= 100) chk("bus_timeout", 32'h1, 32'h0);
        q = dat_o;
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask

    // Counts output states over one whole frame after one settling frame
    task automatic frame_stats();
        hi = 0;
        lo = 0;
        z = 0;
        repeat (800) @(posedge clk);
        repeat (800) begin
            @(negedge clk);
            if (s_oe === 1'b0) z++;
            else if (s_oe === 1'b1 && s_out === 1'b1) hi++;
            else if (s_oe === 1'b1 && s_out === 1'b0) lo++;
        end
    endtask

    // Counts rising edges of each output clock and low cycles of marker 0
    task automatic clk_stats();
        logic [3:0] prev;
        prev = ck_o;
        fl = 0;
        for (int i = 0; i < 4; i++) begin
            ne[i] = 0;
        end
        repeat (1000) begin
            @(negedge clk);
            for (int i = 0; i < 4; i++) begin
                if (ck_o[i] === 1'b1 && prev[i] === 1'b0) begin
                    ne[i]++;
                end
            end
            if (fm_o[0] === 1'b0) begin
                fl++;
            end
            prev = ck_o;
        end
    endtask

    task automatic fill_cm(input logic [31:0] w);
        for (int m = 0; m < CH; m++) bus(1, 16'h1000 + 16'(4 * m), w);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        bus(0, OFS_OTC, 0);
        chk("otc_reset", RST_OTC, q);
        chk("otc_rates", 32'h0004080c, q);
        bus(0, OFS_GCW, 0);
        chk("gcw_reset", RST_GCW, q);
        bus(1, OFS_OTC, 32'h0f1e2d3c);
        bus(0, OFS_OTC, 0);
        chk("otc_prog", 32'h0f1e2d3c, q);
        bus(1, OFS_OTC, RST_OTC);
        bus(1, OFS_GCW, 32'hffffffff);
        bus(0, OFS_GCW, 0);
        chk("gcw_fields", 32'h003301f3, q);
        bus(1, OFS_GCW, 32'h0);
        bus(0, 16'h0f00, 0);
        chk("unmapped", 32'h0, q);
    endtask

    task automatic t_data_mem();
        bus(1, 16'h3000, 32'hdeadbeef);
        chk("dm_write_err", 32'h1, {31'h0, e});
        repeat (3200) @(posedge clk);
        bus(0, 16'h3000, 0);
        chk("dm_word0", 32'h10111213, q);
        bus(0, 16'h3004, 0);
        chk("dm_word1", 32'h14151617, q);
    endtask

    task automatic t_init();
        bus(1, OFS_INIT_VAL, {FN_HIGH, 29'h0});
        bus(1, OFS_INIT_EN, 32'h1);
        repeat (20) @(posedge clk);
        bus(0, OFS_INIT_EN, 0);
        chk("init_done", 32'h0, {31'h0, q[0]});
        bus(0, 16'h101c, 0);
        chk("init_last", {FN_HIGH, 29'h0}, q);
        frame_stats();
        chk("force_high", 32'd800, 32'(hi));
        chk("high_lo", 32'h0, 32'(lo + z));
    endtask

    task automatic t_hiz();
        logic [2:0] codes[3] = '{FN_HIZ, 3'h6, 3'h7};
        foreach (codes[i]) begin
            fill_cm({codes[i], 29'h0});
            frame_stats();
            chk("hiz_frame", 32'd800, 32'(z));
        end
    endtask

    task automatic t_message();
        fill_cm({FN_MESSAGE, 21'h0, 8'hff});
        bus(1, 16'h2000, 32'h0);
        bus(1, 16'h2004, 32'h0);
        bus(0, 16'h1004, 0);
        chk("cm_low_byte", {FN_MESSAGE, 29'h0}, q);
        frame_stats();
        chk("msg_low", 32'd800, 32'(lo));
    endtask

    // Nominal rates over 10 us: 327.68, 163.84 and 81.92 rising edges
    task automatic t_clocks();
        clk_stats();
        chk("ck1_rate", 32'h1, 32'(ne[1] >= 327 && ne[1] <= 328));
        chk("ck2_rate", 32'h1, 32'(ne[2] >= 163 && ne[2] <= 164));
        chk("ck3_rate", 32'h1, 32'(ne[3] >= 81 && ne[3] <= 82));
        chk("fm_neg", 32'h1, 32'(fl > 0 && fl < 40));
        // Pair 3 follows the 8 MHz reference at no faster rate
        bus(1, OFS_OTC, 32'h0104082c);
        clk_stats();
        chk("ck3_ext", 32'h1, 32'(ne[3] >= 79 && ne[3] <= 81));
        chk("ck2_keep", 32'h1, 32'(ne[2] >= 163 && ne[2] <= 164));
        chk("fm_pos", 32'h1, 32'(fl > 960 && fl < 1000));
        bus(1, OFS_OTC, RST_OTC);
    endtask

    // Source byte 8'h17 has four ones, 8'h10 one
    task automatic t_switch();
        fill_cm({FN_CONST, 18'h0, 3'd7, 8'h00});
        frame_stats();
        chk("const_ones", 32'h1, 32'(hi >= 370 && hi <= 430));
        chk("const_drv", 32'h0, 32'(z));
        fill_cm({FN_VAR, 18'h0, 3'd0, 8'h00});
        frame_stats();
        chk("var_ones", 32'h1, 32'(hi >= 80 && hi <= 130));
        chk("var_drv", 32'h0, 32'(z));
        fill_cm({FN_SPARE, 18'h0, 3'd7, 8'h00});
        frame_stats();
        chk("spare_ones", 32'h1, 32'(hi >= 370 && hi <= 430));
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        end_of_test();
    end

    initial begin
        repeat (4) @(posedge clk);
        chk("oe_in_reset", 32'h0, {31'h0, s_oe});
        reset_n <= 1'b1;
        t_regs();
        t_clocks();
        t_data_mem();
        t_init();
        t_hiz();
        t_message();
        t_switch();
        end_of_test();
    end
endmodule
